// [logic/mmap_top.sv]
`timescale 1ns/1ns
// What this block does
// [RL1] After reset the program counter is zero so the first fetch is address zero.
// [RL2] Program counter is sixteen bits; only the lower 32k bytes hold memory.
// [RL3] Each interrupt has a fixed vector; taking it loads that vector into the counter.
// [RL4] External interrupt ten vectors to address 000B hex.
// [RL5] Vector slots are eight bytes apart.
// [RL6] Vectors of unused interrupts are plain program memory, no special decoding.
// [RL7] Program and data spaces are separate; data reached by eight-bit addresses.
// [RL8] Sixteen-bit data addresses are formed from the data pointer register.
// [RL9] Internal data RAM is 256 bytes and holds the stack.
// [RL10] External data RAM is 1k bytes; 40 bytes of it are display RAM.
// [RL11] The 32k flash program memory can be read and written in system.
// [RL12] Fetches above 32k select no memory; the returned byte is undefined.
module mmap_top
  import mmap_pkg::*;
#(
  parameter int NUM_VEC = mmap_pkg::MMAP_NUM_VEC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       fetch_req,
  input  wire logic                       pc_load,
  input  wire logic [15:0]                pc_load_val,
  input  wire logic                       int_take,
  input  wire logic [4:0]                 int_idx,
  output logic      [15:0]                pc,
  output logic      [7:0]                 fetch_data,
  output logic                            fetch_valid,
  output logic                            fetch_oob,
  input  wire logic                       prog_we,
  input  wire logic [15:0]                prog_waddr,
  input  wire logic [7:0]                 prog_wdata,
  input  wire logic                       data_pointer_register_load,
  input  wire logic [15:0]                data_pointer_register_val,
  input  wire mmap_pkg::mmap_dkind_t      d_kind,
  input  wire logic                       d_we,
  input  wire logic [7:0]                 d_addr8,
  input  wire logic [7:0]                 d_wdata,
  output logic      [7:0]                 d_rdata,
  output logic                            d_valid,
  output logic                            d_lcd_hit,
  output logic      [15:0]                data_pointer_register,
  output logic      [7:0]                 sp
);
  import mmap_pkg::*;

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [15:0] vec_addr;
  logic [15:0] vec_off;

  // Vector k sits at base + 8*k; index 1 gives 000B
  assign vec_off  = 16'(int_idx) * MMAP_VEC_STRIDE;              // RL5
  assign vec_addr = MMAP_VEC_BASE + vec_off;                     // RL3 RL4

  always_comb begin
    pc_nxt = pc_r;
    if (int_take && (int'(int_idx) < NUM_VEC)) begin
      pc_nxt = vec_addr;                                         // RL3
    end else if (pc_load) begin
      pc_nxt = pc_load_val;
    end else if (fetch_req) begin
      pc_nxt = 16'(pc_r + 16'h0001);                             // RL2
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= MMAP_RESET_PC;                                     // RL1
    end else begin
      pc_r <= pc_nxt;
    end
  end
  assign pc = pc_r;

  // ----------------------------------------------------------------
  // Flash program memory
  // ----------------------------------------------------------------
  // Vector slots get no decode here: they are ordinary bytes
  logic        prog_hit;
  logic        prog_en;
  logic        prog_wr;
  logic [14:0] prog_addr;
  logic [7:0]  prog_rdata;
  logic        fetch_pend_r;
  logic        fetch_oob_r;

  assign prog_hit  = (pc_r[15] == 1'b0);                         // RL2 RL6
  assign prog_wr   = prog_we && (prog_waddr[15] == 1'b0);        // RL11
  // Writes take the port for one cycle; a fetch in that cycle does not read pc and gives no fetch_valid
  assign prog_addr = prog_wr ? prog_waddr[14:0] : pc_r[14:0];
  assign prog_en   = prog_wr || (fetch_req && prog_hit);         // RL12

  mmap_mem #(
    .AW    (MMAP_PROG_AW),
    .DEPTH (MMAP_PROG_BYTES)
  ) u_flash (
    .clk   (clk),
    .en    (prog_en),
    .we    (prog_wr),
    .addr  (prog_addr),
    .wdata (prog_wdata),
    .rdata (prog_rdata)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_pend_r <= 1'b0;
      fetch_oob_r  <= 1'b0;
    end else begin
      fetch_pend_r <= fetch_req && !prog_wr;
      fetch_oob_r  <= fetch_req && !prog_wr && !prog_hit;        // RL12
    end
  end

  assign fetch_valid = fetch_pend_r;
  assign fetch_oob   = fetch_oob_r;
  assign fetch_data  = fetch_oob_r ? MMAP_UNDEF_BYTE : prog_rdata;  // RL12

  // ----------------------------------------------------------------
  // Data pointer and stack pointer
  // ----------------------------------------------------------------
  logic [15:0] data_pointer_register_r;
  logic [7:0]  sp_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_pointer_register_r <= MMAP_PTR_RESET;
    end else if (data_pointer_register_load) begin
      data_pointer_register_r <= data_pointer_register_val;                                        // RL8
    end
  end
  assign data_pointer_register = data_pointer_register_r;

  // Push pre-increments, pop post-decrements, wrapping inside 256 bytes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= MMAP_SP_RESET;
    end else if (d_kind == MMAP_STACK) begin
      sp_r <= d_we ? 8'(sp_r + 8'h01) : 8'(sp_r - 8'h01);        // RL9
    end
  end
  assign sp = sp_r;

  // ----------------------------------------------------------------
  // Data space decode
  // ----------------------------------------------------------------
  logic        int_ram_en;
  logic [7:0]  int_ram_addr;
  logic [7:0]  int_ram_rdata;
  logic        ext_ram_hit;
  logic        ext_ram_en;
  logic [7:0]  ext_ram_rdata;
  logic        lcd_hit;
  logic [1:0]  d_sel_r;
  logic        d_valid_r;
  logic        lcd_hit_r;

  // Separate space from program memory; 8-bit addresses pick internal RAM
  assign int_ram_addr = (d_kind == MMAP_STACK) ?
                        (d_we ? 8'(sp_r + 8'h01) : sp_r) : d_addr8;  // RL9
  assign int_ram_en   = (d_kind == MMAP_DIRECT) || (d_kind == MMAP_STACK);  // RL7
  assign ext_ram_hit  = (data_pointer_register_r < 16'(MMAP_EXT_RAM_BYTES));      // RL10
  assign ext_ram_en   = (d_kind == MMAP_PTR16) && ext_ram_hit;   // RL8
  assign lcd_hit   = (d_kind == MMAP_PTR16) && (data_pointer_register_r >= MMAP_LCD_BASE) &&
                     (data_pointer_register_r < 16'(MMAP_LCD_BASE + 16'(MMAP_LCD_BYTES)));  // RL10

  mmap_mem #(
    .AW    (MMAP_INT_RAM_AW),
    .DEPTH (MMAP_INT_RAM_BYTES)
  ) u_int_ram (
    .clk   (clk),
    .en    (int_ram_en),
    .we    (d_we),
    .addr  (int_ram_addr),
    .wdata (d_wdata),
    .rdata (int_ram_rdata)
  );

  mmap_mem #(
    .AW    (MMAP_EXT_RAM_AW),
    .DEPTH (MMAP_EXT_RAM_BYTES)
  ) u_ext_ram (
    .clk   (clk),
    .en    (ext_ram_en),
    .we    (d_we),
    .addr  (data_pointer_register_r[9:0]),
    .wdata (d_wdata),
    .rdata (ext_ram_rdata)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_sel_r   <= MMAP_NONE;
      d_valid_r <= 1'b0;
      lcd_hit_r <= 1'b0;
    end else begin
      d_valid_r <= (d_kind != MMAP_NONE);
      lcd_hit_r <= lcd_hit;
      if (int_ram_en) begin
        d_sel_r <= MMAP_DIRECT;
      end else if (ext_ram_en) begin
        d_sel_r <= MMAP_PTR16;
      end else begin
        d_sel_r <= MMAP_NONE;
      end
    end
  end

  always_comb begin
    case (d_sel_r)
      MMAP_DIRECT: d_rdata = int_ram_rdata;
      MMAP_PTR16:  d_rdata = ext_ram_rdata;
      default:     d_rdata = MMAP_UNDEF_BYTE;
    endcase
  end

  assign d_valid   = d_valid_r;
  assign d_lcd_hit = lcd_hit_r;
endmodule

// [logic/mmap_pkg.sv]
package mmap_pkg;
  // ----------------------------------------------------------------
  // Address spaces
  // ----------------------------------------------------------------
  localparam int          MMAP_PC_W        = 16;
  localparam int          MMAP_PROG_BYTES  = 32768;
  localparam int          MMAP_PROG_AW     = 15;
  localparam int          MMAP_INT_RAM_BYTES = 256;
  localparam int          MMAP_INT_RAM_AW    = 8;
  localparam int          MMAP_EXT_RAM_BYTES = 1024;
  localparam int          MMAP_EXT_RAM_AW    = 10;
  localparam int          MMAP_LCD_BYTES   = 40;
  localparam int          MMAP_NUM_VEC     = 24;
  // ----------------------------------------------------------------
  // Vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MMAP_RESET_PC    = 16'h0000;
  localparam logic [15:0] MMAP_VEC_BASE    = 16'h0003;
  localparam logic [15:0] MMAP_VEC_STRIDE  = 16'h0008;
  localparam logic [4:0]  MMAP_EINT10_IDX  = 5'h01;
  localparam logic [15:0] MMAP_LCD_BASE    = 16'h0000;
  localparam logic [7:0]  MMAP_UNDEF_BYTE  = 8'hFF;
  localparam logic [7:0]  MMAP_SP_RESET    = 8'h07;
  localparam logic [15:0] MMAP_PTR_RESET   = 16'h0000;
  // ----------------------------------------------------------------
  // Access kinds of the data-space port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MMAP_DIRECT  = 2'b00,
    MMAP_PTR16   = 2'b01,
    MMAP_STACK   = 2'b10,
    MMAP_NONE    = 2'b11
  } mmap_dkind_t;
endpackage

// [logic/mmap_mem.sv]
`timescale 1ns/1ns
// Single-port byte memory with registered read data
module mmap_mem #(
  parameter int AW = 8,
  parameter int DEPTH = 256
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// [tb/mmap_props.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Port checks
// ----------------------------------------
module mmap_props
  import mmap_pkg::*;
#(
  parameter int NUM_VEC = 24
) (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  fetch_req,
  input wire logic                  pc_load,
  input wire logic                  int_take,
  input wire logic [4:0]            int_idx,
  input wire logic [15:0]           pc,
  input wire logic [7:0]            fetch_data,
  input wire logic                  fetch_valid,
  input wire logic                  fetch_oob,
  input wire logic                  prog_we,
  input wire logic                  data_pointer_register_load,
  input wire logic [15:0]           data_pointer_register_val,
  input wire mmap_pkg::mmap_dkind_t d_kind,
  input wire logic                  d_we,
  input wire logic                  d_valid,
  input wire logic                  d_lcd_hit,
  input wire logic [15:0]           data_pointer_register,
  input wire logic [7:0]            sp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take; fetch_req && !prog_we; endsequence
  sequence s_undef; fetch_valid && fetch_oob && fetch_data == 8'hff; endsequence
  property p_adv; fetch_req && !int_take && !pc_load |=> pc == $past(pc) + 16'h0001; endproperty
  a_adv: assert property (p_adv) else $error("pc did not advance");
  property p_vec; int_take && int_idx < NUM_VEC |=> pc == 16'h0003 + {$past(int_idx), 3'b000};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector slot");
  property p_ext10; int_take && int_idx == 5'h01 |=> pc == 16'h000b; endproperty
  a_ext10: assert property (p_ext10) else $error("wrong vector for index one");
  property p_undef; s_take ##0 pc[15] |=> s_undef; endproperty
  a_undef: assert property (p_undef) else $error("fetch above range not undefined");
  property p_inb; s_take ##0 !pc[15] |=> fetch_valid && !fetch_oob; endproperty
  a_inb: assert property (p_inb) else $error("fetch in range missing");
  property p_dval; d_kind != MMAP_NONE |=> d_valid; endproperty
  a_dval: assert property (p_dval) else $error("data access not answered");
  property p_data_pointer_register; data_pointer_register_load |=> data_pointer_register == $past(data_pointer_register_val); endproperty
  a_data_pointer_register: assert property (p_data_pointer_register) else $error("data pointer not loaded");
  property p_push; d_kind == MMAP_STACK && d_we |=> sp == $past(sp) + 8'h01; endproperty
  a_push: assert property (p_push) else $error("push did not raise sp");
  property p_lcd; d_kind == MMAP_PTR16 && data_pointer_register < 40 |=> d_lcd_hit; endproperty
  a_lcd: assert property (p_lcd) else $error("display ram not flagged");
endmodule

// [tb/mmap_cpu_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Core fetch side
// ----------------------------------------
// A running core holds its fetch request as a level, never shorter than a cycle
module mmap_cpu_model (
  input  wire logic go,
  output logic      fetch_req
);
  assign fetch_req = go;
endmodule

// [tb/mmap_top_tb.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Bench
// ----------------------------------------
module mmap_top_tb;
  import mmap_pkg::*;
  localparam int NV = 24;
  logic        clk = 0, rst_b = 0, go = 0, fetch_req, pc_load = 0, int_take = 0;
  logic        prog_we = 0, data_pointer_register_load = 0, d_we = 0, fetch_valid, fetch_oob, d_valid, d_lcd_hit;
  logic [15:0] pc_load_val = 0, prog_waddr = 0, data_pointer_register_val = 0, pc, data_pointer_register;
  logic [7:0]  prog_wdata = 0, d_addr8 = 0, d_wdata = 0, v, fetch_data, d_rdata, sp;
  logic [7:0]  b [16];
  logic [4:0]  int_idx = 0;
  mmap_dkind_t d_kind = MMAP_NONE;
  int          err_total = 0, compares = 0;
  mmap_top #(.NUM_VEC(NV)) i_dut (.*);
  mmap_cpu_model i_cpu (.go(go), .fetch_req(fetch_req));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] vec(input int i);
    return 16'h0003 + 16'(i) * 16'h0008;
  endfunction
  task automatic tick;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Jump, then one fetch; result is settled on return
  task automatic at(input logic [15:0] a);
    pc_load <= 1;
    pc_load_val <= a;
    tick;
    pc_load <= 0;
    go <= 1;
    tick;
    go <= 0;
    #1;
  endtask
  task automatic test_done;
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(45));
    repeat (2) tick;
    rst_b <= 1;
    #1 chk("pc", 16'h0000, pc);
    for (int i = 0; i < 16; i++) begin
      b[i] = 8'($urandom);
      prog_we <= 1;
      prog_waddr <= 16'(i);
      prog_wdata <= b[i];
      tick;
    end
    // Write above the implemented range must be dropped
    prog_waddr <= 16'h8000;
    prog_wdata <= 8'h00;
    tick;
    prog_we <= 0;
    for (int i = 0; i < 16; i++) begin
      at(16'(i));
      chk("flash", b[i], fetch_data);
      chk("fetch_valid", 16'h0001, 16'(fetch_valid));
    end
    at(16'h8000);
    chk("undef", 16'h01ff, {7'h00, fetch_oob, fetch_data});
    at(16'hffff);
    chk("wrap", 16'h0000, pc);
    for (int i = NV - 1; i >= 0; i--) begin
      int_take <= 1;
      int_idx <= 5'(i);
      tick;
      int_take <= 0;
      #1 chk("vector", vec(i), pc);
    end
    // Index beyond the vector table is ignored: pc keeps the last vector
    int_take <= 1;
    int_idx <= 5'(NV);
    tick;
    int_take <= 0;
    #1 chk("vector", vec(0), pc);
    // Reset again in mid-run: counter restarts at zero
    rst_b <= 0;
    tick;
    rst_b <= 1;
    #1 chk("pc", 16'h0000, pc);
    chk("sp", 16'h0007, sp);
    chk("d_rdata", 16'h00ff, d_rdata);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      d_kind <= MMAP_DIRECT;
      d_we <= 1;
      d_addr8 <= 8'($urandom);
      d_wdata <= v;
      tick;
      d_we <= 0;
      tick;
      d_kind <= MMAP_NONE;
      #1 chk("int_ram", v, d_rdata);
      chk("d_valid", 16'h0001, 16'(d_valid));
    end
    d_kind <= MMAP_STACK;
    d_we <= 1;
    tick;
    d_we <= 0;
    #1 chk("sp", 16'h0008, sp);
    tick;
    d_kind <= MMAP_NONE;
    #1 chk("pop", v, d_rdata);
    for (int i = 0; i < 3; i++) begin
      data_pointer_register_load <= 1;
      data_pointer_register_val <= i == 0 ? 16'($urandom_range(39, 0)) : i == 1 ? 16'h03ff : 16'h0400;
      tick;
      data_pointer_register_load <= 0;
      d_kind <= MMAP_PTR16;
      d_we <= 1;
      tick;
      d_we <= 0;
      tick;
      d_kind <= MMAP_NONE;
      #1 chk("ext_ram", i == 2 ? 8'hff : v, d_rdata);
      chk("lcd", 16'(i == 0), 16'(d_lcd_hit));
    end
    test_done;
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
bind mmap_top mmap_props #(.NUM_VEC(NUM_VEC)) i_props (.*);
